// >>> pkg/bdps_pkg.sv
package bdps_pkg;
	// ************************************************************
	// strap codes: divider band index on the analog strap pin
	// ************************************************************
	localparam int STRAP_BAND_W = 4;
	localparam logic STRAP_FLASH_DEFAULT = 1'b1;

	typedef enum logic [2:0] {
		BDPS_DB_NO_RESPONSE = 3'h0,
		BDPS_DB_WAIT_SUPPLY_INT = 3'h1,
		BDPS_DB_HOST_WAIT_INT = 3'h2,
		BDPS_DB_WAIT_SUPPLY_EXT = 3'h3,
		BDPS_DB_HOST_WAIT_EXT = 3'h4,
		BDPS_DB_NO_WAIT = 3'h5
	} bdps_db_mode_t;

	typedef enum logic [2:0] {
		BDPS_CFG_SAFE = 3'h0,
		BDPS_CFG_INF_WAIT = 3'h1,
		BDPS_CFG_PROFILE1 = 3'h2,
		BDPS_CFG_PROFILE2 = 3'h3,
		BDPS_CFG_PROFILE3 = 3'h4,
		BDPS_CFG_PROFILE4 = 3'h5,
		BDPS_CFG_PROFILE5 = 3'h6,
		BDPS_CFG_RESERVED = 3'h7
	} bdps_cfg_t;

	typedef enum logic [1:0] {
		BDPS_PWR_ACTIVE = 2'h0,
		BDPS_PWR_IDLE = 2'h1,
		BDPS_PWR_SLEEP = 2'h2
	} bdps_pwr_t;

	typedef enum logic [1:0] {
		BDPS_ROLE_NONE = 2'h0,
		BDPS_ROLE_SOURCE = 2'h1,
		BDPS_ROLE_SINK = 2'h2,
		BDPS_ROLE_DUAL = 2'h3
	} bdps_role_t;

	// ************************************************************
	// profile electrical values, millivolt and milliamp
	// ************************************************************
	localparam logic [15:0] V5_MV = 16'h1388;
	localparam logic [15:0] V20_MV = 16'h4E20;
	localparam logic [15:0] I09_MA = 16'h0384;
	localparam logic [15:0] I30_MA = 16'h0BB8;

	// ************************************************************
	// clocks and timing
	// ************************************************************
	localparam int CLK_HZ = 20_000_000;
	localparam int CORE_ACTIVE_HZ = 12_000_000;
	localparam int CORE_IDLE_HZ = 5_000_000;
	localparam int CORE_SLEEP_HZ = 100_000;
	localparam int SLOW_OSC_HZ = 100_000;
	localparam int SLOW_DIV = CLK_HZ / SLOW_OSC_HZ;
	localparam int IDLE_DIV = CLK_HZ / CORE_IDLE_HZ;
	localparam int FAST_OSC_START_US = 10;
	localparam int FAST_OSC_START_CYC = (FAST_OSC_START_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int DIV_W = 8;
endpackage : bdps_pkg

// >>> pkg/bdps_wake_if.sv
interface bdps_wake_if;
	import bdps_pkg::*;
	logic attach_evt;
	logic i2c_evt;
	logic pd_evt;
	logic wake_req;
	logic pd_drop;
	bdps_pwr_t state;

	modport filt (input state, input attach_evt, input i2c_evt, input pd_evt,
		output wake_req, output pd_drop);
	modport ctl (output state, output attach_evt, output i2c_evt, output pd_evt,
		input wake_req, input pd_drop);
endinterface : bdps_wake_if

// >>> design/bdps_wake_filter.sv
module bdps_wake_filter (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// wake events
	bdps_wake_if.filt wk
);
	import bdps_pkg::*;

	logic wake_q;
	logic drop_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_q <= 1'b0;
		end else begin
			unique case (wk.state)
				BDPS_PWR_IDLE: wake_q <= wk.attach_evt | wk.i2c_evt | wk.pd_evt;
				BDPS_PWR_SLEEP: wake_q <= wk.attach_evt | wk.i2c_evt;
				default: wake_q <= 1'b0;
			endcase
		end
	end

	// message that woke from idle is thrown away
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			drop_q <= 1'b0;
		end else begin
			drop_q <= (wk.state == BDPS_PWR_IDLE) && wk.pd_evt;
		end
	end

	assign wk.wake_req = wake_q;
	assign wk.pd_drop = drop_q;
endmodule : bdps_wake_filter

// >>> design/bdps_div.sv
module bdps_div #(
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic run_in,
	output logic tick_out
);
	import bdps_pkg::*;

	logic [DIV_W-1:0] cnt_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else if (!run_in) begin
			cnt_q <= '0;
			tick_out <= 1'b0;
		end else if (cnt_q == DIV_W'(DIV - 1)) begin
			cnt_q <= '0;
			tick_out <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick_out <= 1'b0;
		end
	end
endmodule : bdps_div

// >>> design/bdps_ctl.sv
// Summary of operation
// - after power-up, try loading configuration over SPI or I2C
// - no configuration obtained: apply strapped default configuration behaviour
// - safe default: ports off; from VBUS only legacy sink
// - infinite wait: remain in boot until configuration arrives
// - profile one: source only, internal switch, 5 V 3 A, no alt modes
// - profile two: sink only, internal switch, 5 V 0.9-3 A
// - profile three: sink only, internal switch, 5-20 V 0.9-3 A
// - profile four: sink, external switch, 5 V sink, 5 V 3 A source
// - profile five: sink, external switch, 5-20 V sink, 5 V 3 A source
// - exactly one of active, idle, sleep at all times
// - detection always; I2C active/idle; PD, SPI active; sleep only unconnected
// - core 12 MHz, 4-6 MHz, 100 kHz; fast oscillator off only asleep
// - PD message wakes idle, never sleep
// - I2C traffic or attach change wakes idle and sleep
// - PD message that woke from idle is discarded
// - regulator fed from VBUS: ports sink only
// - fast oscillator clocks core normally; slow one clocks timers and low power
// - dead-battery and default configuration come from straps at boot
module bdps_ctl (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// strap pins
	input wire logic flash_data_in_pin_in,
	input wire logic [bdps_pkg::STRAP_BAND_W-1:0] first_analog_input_pin_in,
	// supply status
	input wire logic main_supply_input_in,
	input wire logic vbus_present_in,
	// configuration load
	input wire logic cfg_loaded_in,
	input wire logic cfg_fail_in,
	// port and host events
	input wire logic port_connected_in,
	input wire logic attach_change_in,
	input wire logic i2c_activity_in,
	input wire logic pd_msg_in,
	input wire logic idle_req_in,
	input wire logic sleep_req_in,
	// boot outputs
	output logic boot_busy_out,
	output logic cfg_fetch_out,
	output bdps_pkg::bdps_db_mode_t db_mode_out,
	output bdps_pkg::bdps_cfg_t default_cfg_out,
	output logic default_applied_out,
	output logic ports_enabled_out,
	output bdps_pkg::bdps_role_t port_role_out,
	output logic legacy_sink_out,
	output logic ext_switch_out,
	output logic external_sink_switch_ctl_out,
	output logic first_internal_hv_path_out,
	output logic [15:0] src_mv_out,
	output logic [15:0] src_ma_out,
	output logic [15:0] snk_min_mv_out,
	output logic [15:0] snk_max_mv_out,
	output logic [15:0] snk_min_ma_out,
	output logic [15:0] snk_max_ma_out,
	output logic alt_modes_out,
	output logic sink_only_out,
	// power state outputs
	output bdps_pkg::bdps_pwr_t pwr_state_out,
	output logic fast_osc_en_out,
	output logic slow_osc_en_out,
	output logic core_tick_out,
	output logic timer_tick_out,
	output logic detect_en_out,
	output logic i2c_en_out,
	output logic pd_en_out,
	output logic spi_en_out,
	output logic pd_drop_out
);
	import bdps_pkg::*;

	// ************************************************************
	// input synchronisers
	// ************************************************************
	localparam int SYN_W = 9 + STRAP_BAND_W;
	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic [SYN_W-1:0] raw;
	assign raw = {flash_data_in_pin_in, first_analog_input_pin_in, main_supply_input_in,
		vbus_present_in, port_connected_in, attach_change_in, i2c_activity_in, pd_msg_in,
		idle_req_in, sleep_req_in};

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			syn1_q <= '0;
			syn2_q <= '0;
		end else begin
			syn1_q <= raw;
			syn2_q <= syn1_q;
		end
	end

	logic s_flash;
	logic [STRAP_BAND_W-1:0] s_band;
	logic s_vin;
	logic s_vbus;
	logic s_conn;
	logic s_att;
	logic s_i2c;
	logic s_pd;
	logic s_idle;
	logic s_sleep;
	assign {s_flash, s_band, s_vin, s_vbus, s_conn, s_att, s_i2c, s_pd, s_idle, s_sleep} = syn2_q;

	// ************************************************************
	// strap decode
	// ************************************************************
	function automatic bdps_db_mode_t db_decode(input logic fl, input logic [3:0] b);
		if (fl) begin
			unique case (b)
				4'h0, 4'h1: db_decode = BDPS_DB_NO_RESPONSE;
				4'h2: db_decode = BDPS_DB_WAIT_SUPPLY_INT;
				4'h3: db_decode = BDPS_DB_HOST_WAIT_INT;
				4'h4: db_decode = BDPS_DB_WAIT_SUPPLY_EXT;
				4'h5: db_decode = BDPS_DB_HOST_WAIT_EXT;
				default: db_decode = BDPS_DB_NO_WAIT;
			endcase
		end else begin
			unique case (b)
				4'h0, 4'h1, 4'h8: db_decode = BDPS_DB_NO_RESPONSE;
				4'h3: db_decode = BDPS_DB_HOST_WAIT_INT;
				4'h5: db_decode = BDPS_DB_HOST_WAIT_EXT;
				default: db_decode = BDPS_DB_NO_WAIT;
			endcase
		end
	endfunction : db_decode

	function automatic bdps_cfg_t cfg_decode(input logic fl, input logic [3:0] b);
		if (fl) begin
			unique case (b)
				4'h3, 4'h5: cfg_decode = BDPS_CFG_INF_WAIT;
				default: cfg_decode = BDPS_CFG_SAFE;
			endcase
		end else begin
			unique case (b)
				4'h0, 4'h1: cfg_decode = BDPS_CFG_PROFILE1;
				4'h2: cfg_decode = BDPS_CFG_PROFILE2;
				4'h3, 4'h5: cfg_decode = BDPS_CFG_INF_WAIT;
				4'h4: cfg_decode = BDPS_CFG_PROFILE3;
				4'h6: cfg_decode = BDPS_CFG_PROFILE4;
				4'h7, 4'h8: cfg_decode = BDPS_CFG_RESERVED;
				default: cfg_decode = BDPS_CFG_PROFILE5;
			endcase
		end
	endfunction : cfg_decode

	// ************************************************************
	// boot sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		BDPS_B_STRAP = 3'h0,
		BDPS_B_SUPPLY = 3'h1,
		BDPS_B_FETCH = 3'h2,
		BDPS_B_DEFAULT = 3'h3,
		BDPS_B_RUN = 3'h4
	} bdps_boot_t;

	bdps_boot_t boot_q;
	logic strap_done_q;
	logic ext_sw;
	logic int_sw;
	logic db_hold;
	logic from_vbus;
	logic host_wait;
	logic [2:0] phase_q;

	assign from_vbus = s_vbus && !s_vin;
	assign ext_sw = (db_mode_out == BDPS_DB_WAIT_SUPPLY_EXT) || (db_mode_out == BDPS_DB_HOST_WAIT_EXT);
	assign int_sw = (db_mode_out == BDPS_DB_WAIT_SUPPLY_INT) || (db_mode_out == BDPS_DB_HOST_WAIT_INT);
	assign host_wait = (db_mode_out == BDPS_DB_HOST_WAIT_INT) || (db_mode_out == BDPS_DB_HOST_WAIT_EXT);
	assign db_hold = !s_vin && (db_mode_out != BDPS_DB_NO_WAIT) && !host_wait;

	// mod-5 phase: 12 MHz core; 2 marks sync settled
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) phase_q <= '0;
		else phase_q <= (phase_q == 3'h4) ? 3'h0 : phase_q + 3'h1;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_done_q <= 1'b0;
			db_mode_out <= BDPS_DB_NO_RESPONSE;
			default_cfg_out <= BDPS_CFG_SAFE;
		end else if (!strap_done_q && phase_q == 3'h2) begin
			strap_done_q <= 1'b1;
			db_mode_out <= db_decode(s_flash, s_band);
			default_cfg_out <= cfg_decode(s_flash, s_band);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_q <= BDPS_B_STRAP;
		end else begin
			unique case (boot_q)
				BDPS_B_STRAP: if (strap_done_q) boot_q <= BDPS_B_SUPPLY;
				BDPS_B_SUPPLY: if (!db_hold) boot_q <= BDPS_B_FETCH;
				BDPS_B_FETCH: begin
					if (cfg_loaded_in) begin
						boot_q <= BDPS_B_RUN;
					end else if (cfg_fail_in && !host_wait
						&& default_cfg_out != BDPS_CFG_INF_WAIT) begin
						boot_q <= BDPS_B_DEFAULT;
					end
				end
				BDPS_B_DEFAULT: boot_q <= BDPS_B_RUN;
				BDPS_B_RUN: boot_q <= BDPS_B_RUN;
				default: boot_q <= BDPS_B_STRAP;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_busy_out <= 1'b1;
			cfg_fetch_out <= 1'b0;
			default_applied_out <= 1'b0;
		end else begin
			boot_busy_out <= boot_q != BDPS_B_RUN;
			cfg_fetch_out <= boot_q == BDPS_B_FETCH;
			if (boot_q == BDPS_B_DEFAULT) default_applied_out <= 1'b1;
		end
	end

	// ************************************************************
	// default profile outputs
	// ************************************************************
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ports_enabled_out <= 1'b0;
			port_role_out <= BDPS_ROLE_NONE;
			legacy_sink_out <= 1'b0;
			ext_switch_out <= 1'b0;
			src_mv_out <= '0;
			src_ma_out <= '0;
			snk_min_mv_out <= '0;
			snk_max_mv_out <= '0;
			snk_min_ma_out <= '0;
			snk_max_ma_out <= '0;
			alt_modes_out <= 1'b0;
		end else if (boot_q == BDPS_B_DEFAULT) begin
			alt_modes_out <= 1'b0;
			ports_enabled_out <= 1'b1;
			legacy_sink_out <= 1'b0;
			src_mv_out <= '0;
			src_ma_out <= '0;
			snk_min_mv_out <= '0;
			snk_max_mv_out <= '0;
			snk_min_ma_out <= '0;
			snk_max_ma_out <= '0;
			ext_switch_out <= 1'b0;
			port_role_out <= BDPS_ROLE_SINK;
			unique case (default_cfg_out)
				BDPS_CFG_PROFILE1: begin
					port_role_out <= from_vbus ? BDPS_ROLE_SINK : BDPS_ROLE_SOURCE;
					src_mv_out <= from_vbus ? 16'h0000 : V5_MV;
					src_ma_out <= from_vbus ? 16'h0000 : I30_MA;
				end
				BDPS_CFG_PROFILE2, BDPS_CFG_PROFILE3: begin
					snk_min_mv_out <= V5_MV;
					snk_max_mv_out <= (default_cfg_out == BDPS_CFG_PROFILE3) ? V20_MV : V5_MV;
					snk_min_ma_out <= I09_MA;
					snk_max_ma_out <= I30_MA;
				end
				BDPS_CFG_PROFILE4, BDPS_CFG_PROFILE5: begin
					ext_switch_out <= 1'b1;
					snk_min_mv_out <= V5_MV;
					snk_max_mv_out <= (default_cfg_out == BDPS_CFG_PROFILE5) ? V20_MV : V5_MV;
					snk_min_ma_out <= I09_MA;
					snk_max_ma_out <= I30_MA;
					src_mv_out <= from_vbus ? 16'h0000 : V5_MV;
					src_ma_out <= from_vbus ? 16'h0000 : I30_MA;
				end
				default: begin
					ports_enabled_out <= 1'b0;
					legacy_sink_out <= from_vbus;
					port_role_out <= from_vbus ? BDPS_ROLE_SINK : BDPS_ROLE_NONE;
				end
			endcase
		end
	end

	// dead-battery sink path selection
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			external_sink_switch_ctl_out <= 1'b0;
			first_internal_hv_path_out <= 1'b0;
			sink_only_out <= 1'b0;
		end else begin
			external_sink_switch_ctl_out <= strap_done_q && ext_sw && from_vbus;
			first_internal_hv_path_out <= strap_done_q && int_sw && from_vbus;
			sink_only_out <= from_vbus;
		end
	end

	// ************************************************************
	// power states
	// ************************************************************
	bdps_wake_if wk ();
	bdps_pwr_t pwr_q;
	logic [DIV_W-1:0] osc_cnt_q;
	logic osc_ready;
	logic idle_tick;
	logic slow_tick;

	assign osc_ready = osc_cnt_q == '0;
	assign wk.state = pwr_q;
	assign wk.attach_evt = s_att;
	assign wk.i2c_evt = s_i2c;
	assign wk.pd_evt = s_pd;

	bdps_wake_filter u_wake (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.wk(wk)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwr_q <= BDPS_PWR_ACTIVE;
		end else if (boot_q == BDPS_B_RUN) begin
			unique case (pwr_q)
				BDPS_PWR_ACTIVE: begin
					if (s_sleep && !s_conn) pwr_q <= BDPS_PWR_SLEEP;
					else if (s_idle) pwr_q <= BDPS_PWR_IDLE;
				end
				BDPS_PWR_IDLE: begin
					if (wk.wake_req) pwr_q <= BDPS_PWR_ACTIVE;
					else if (s_sleep && !s_conn) pwr_q <= BDPS_PWR_SLEEP;
				end
				BDPS_PWR_SLEEP: if (wk.wake_req) pwr_q <= BDPS_PWR_IDLE;
				default: pwr_q <= BDPS_PWR_ACTIVE;
			endcase
		end
	end

	// fast oscillator restart delay after leaving sleep
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			osc_cnt_q <= '0;
		end else if (pwr_q == BDPS_PWR_SLEEP) begin
			osc_cnt_q <= DIV_W'(FAST_OSC_START_CYC);
		end else if (!osc_ready) begin
			osc_cnt_q <= osc_cnt_q - 1'b1;
		end
	end

	bdps_div #(.DIV(IDLE_DIV)) u_idle_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(pwr_q == BDPS_PWR_IDLE),
		.tick_out(idle_tick)
	);

	bdps_div #(.DIV(SLOW_DIV)) u_slow_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.run_in(1'b1),
		.tick_out(slow_tick)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwr_state_out <= BDPS_PWR_ACTIVE;
			fast_osc_en_out <= 1'b1;
			slow_osc_en_out <= 1'b1;
			core_tick_out <= 1'b0;
			timer_tick_out <= 1'b0;
			detect_en_out <= 1'b1;
			i2c_en_out <= 1'b0;
			pd_en_out <= 1'b0;
			spi_en_out <= 1'b0;
			pd_drop_out <= 1'b0;
		end else begin
			pwr_state_out <= pwr_q;
			fast_osc_en_out <= pwr_q != BDPS_PWR_SLEEP;
			slow_osc_en_out <= 1'b1;
			timer_tick_out <= slow_tick;
			unique case (pwr_q)
				BDPS_PWR_ACTIVE: core_tick_out <= osc_ready && phase_q < 3'h3;
				BDPS_PWR_IDLE: core_tick_out <= idle_tick;
				default: core_tick_out <= slow_tick;
			endcase
			detect_en_out <= 1'b1;
			i2c_en_out <= (pwr_q != BDPS_PWR_SLEEP) && osc_ready;
			pd_en_out <= (pwr_q == BDPS_PWR_ACTIVE) && osc_ready;
			spi_en_out <= ((pwr_q == BDPS_PWR_ACTIVE) && osc_ready)
				|| (boot_q == BDPS_B_FETCH);
			pd_drop_out <= wk.pd_drop;
		end
	end
endmodule : bdps_ctl

// >>> dv/bdps_ctl_sva.sv
module bdps_ctl_sva (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// supply and port
	input wire logic main_supply_input_in,
	input wire logic vbus_present_in,
	input wire logic port_connected_in,
	// boot
	input wire logic boot_busy_out,
	input wire logic cfg_fetch_out,
	input wire bdps_pkg::bdps_cfg_t default_cfg_out,
	input wire logic default_applied_out,
	input wire logic sink_only_out,
	// power
	input wire bdps_pkg::bdps_pwr_t pwr_state_out,
	input wire logic fast_osc_en_out,
	input wire logic slow_osc_en_out,
	input wire logic detect_en_out,
	input wire logic i2c_en_out,
	input wire logic pd_en_out,
	input wire logic spi_en_out,
	input wire logic pd_drop_out
);
	timeunit 1ns;
	timeprecision 1ns;
	import bdps_pkg::*;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	state_legal_a: assert property (
		pwr_state_out inside {BDPS_PWR_ACTIVE, BDPS_PWR_IDLE, BDPS_PWR_SLEEP})
		else $error("power state code out of range");
	fast_osc_on_a: assert property (
		pwr_state_out != BDPS_PWR_SLEEP && $past(pwr_state_out) != BDPS_PWR_SLEEP
		|-> fast_osc_en_out) else $error("fast osc off outside sleep");
	always_on_a: assert property (
		slow_osc_en_out && detect_en_out) else $error("slow osc or detection off");
	pd_spi_gate_a: assert property (
		pd_en_out || spi_en_out |-> pwr_state_out == BDPS_PWR_ACTIVE
		|| $past(pwr_state_out) == BDPS_PWR_ACTIVE) else $error("pd or spi on outside active");
	i2c_gate_a: assert property (
		i2c_en_out |-> pwr_state_out != BDPS_PWR_SLEEP || $past(pwr_state_out) != BDPS_PWR_SLEEP)
		else $error("i2c on in sleep");
	sleep_unconn_a: assert property (
		$rose(pwr_state_out == BDPS_PWR_SLEEP) |-> !$past(port_connected_in, 4))
		else $error("sleep entered while connected");
	fetch_in_boot_a: assert property (
		cfg_fetch_out |-> boot_busy_out) else $error("fetch outside boot");
	no_wait_default_a: assert property (
		$rose(default_applied_out) |-> default_cfg_out != BDPS_CFG_INF_WAIT)
		else $error("infinite wait left boot by default");
	supply_sink_a: assert property (
		$stable({vbus_present_in, main_supply_input_in}) [*6]
		|-> sink_only_out == (vbus_present_in && !main_supply_input_in))
		else $error("sink only flag wrong");
	pd_wake_a: assert property (
		$rose(pd_drop_out) |-> ##[0:4] pwr_state_out == BDPS_PWR_ACTIVE)
		else $error("dropped message did not wake");
endmodule : bdps_ctl_sva

// >>> dv/bdps_partner.sv
module bdps_partner (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// host config load
	input wire logic cfg_fetch_in,
	input wire logic [1:0] answer_in,
	input wire logic slow_in,
	output logic cfg_loaded_out,
	output logic cfg_fail_out,
	// port partner messages
	input wire logic pd_send_in,
	input wire logic pd_drop_in,
	output logic pd_msg_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [4:0] wait_q;
	logic [3:0] retry_q;

	// host answers every fetch attempt when answer_in is 1 or 2, prompt or slow
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_q <= 5'h01;
			cfg_loaded_out <= 1'b0;
			cfg_fail_out <= 1'b0;
		end else begin
			cfg_loaded_out <= 1'b0;
			cfg_fail_out <= 1'b0;
			if (!cfg_fetch_in || answer_in == 2'h0) begin
				wait_q <= slow_in ? 5'h14 : 5'h01;
			end else if (wait_q != 5'h00) begin
				wait_q <= wait_q - 5'h01;
			end else begin
				cfg_loaded_out <= answer_in == 2'h1;
				cfg_fail_out <= answer_in == 2'h2;
				wait_q <= slow_in ? 5'h14 : 5'h01;
			end
		end
	end

	// lost message is sent again
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			retry_q <= 4'h0;
			pd_msg_out <= 1'b0;
		end else begin
			pd_msg_out <= pd_send_in || retry_q == 4'h1;
			if (pd_drop_in) retry_q <= 4'hA;
			else if (retry_q != 4'h0) retry_q <= retry_q - 4'h1;
		end
	end
endmodule : bdps_partner

// >>> dv/bdps_ctl_tb.sv
module bdps_ctl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bdps_pkg::*;

	// ************************************************************
	// signals
	// ************************************************************
	logic clk_in, rst_n_in, flash_data_in_pin_in, main_supply_input_in, vbus_present_in;
	logic [3:0] first_analog_input_pin_in;
	logic cfg_loaded_in, cfg_fail_in, port_connected_in, attach_change_in, i2c_activity_in;
	logic pd_msg_in, idle_req_in, sleep_req_in, slow, pd_send, inf;
	logic boot_busy_out, cfg_fetch_out, default_applied_out, ports_enabled_out, legacy_sink_out;
	logic ext_switch_out, external_sink_switch_ctl_out, first_internal_hv_path_out;
	logic alt_modes_out, sink_only_out, fast_osc_en_out, slow_osc_en_out, core_tick_out;
	logic timer_tick_out, detect_en_out, i2c_en_out, pd_en_out, spi_en_out, pd_drop_out;
	logic [15:0] src_mv_out, src_ma_out, snk_min_mv_out, snk_max_mv_out, snk_min_ma_out;
	logic [15:0] snk_max_ma_out, r;
	logic [1:0] answer;
	bdps_db_mode_t db_mode_out;
	bdps_cfg_t default_cfg_out;
	bdps_role_t port_role_out;
	bdps_pwr_t pwr_state_out;
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int drops = 0;
	int c;
	// {flash, band, dead battery mode, default config}
	localparam logic [15:0] ROWS [17] = '{16'h1000, 16'h1100, 16'h1210, 16'h1321, 16'h1430,
		16'h1541, 16'h1650, 16'h1950, 16'h0102, 16'h0253, 16'h0321, 16'h0454, 16'h0541,
		16'h0655, 16'h0757, 16'h0807, 16'h0956};

	bdps_ctl DUT (.*);
	bdps_partner u_partner (.clk_in, .rst_n_in, .cfg_fetch_in(cfg_fetch_out), .answer_in(answer),
		.slow_in(slow), .cfg_loaded_out(cfg_loaded_in), .cfg_fail_out(cfg_fail_in),
		.pd_send_in(pd_send), .pd_drop_in(pd_drop_out), .pd_msg_out(pd_msg_in));

	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		if (pd_drop_out === 1'b1) drops <= drops + 1;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			$display("[ERR] %0t run timed out", $time);
			stop_test();
		end
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask : tick

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp, input string what);
		chk({15'h0000, got}, {15'h0000, exp}, what);
	endtask : chk1

	task automatic wait_bit(ref logic s, input logic v, input int lim, input string what);
		int n;
		n = 0;
		while (s !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk1(s, v, what);
	endtask : wait_bit

	task automatic wait_pwr(input bdps_pwr_t v, input int lim);
		int n;
		n = 0;
		while (pwr_state_out !== v && n < lim) begin
			tick(1);
			n++;
		end
		chk(16'(pwr_state_out), 16'(v), "power state");
	endtask : wait_pwr

	task automatic count(ref logic s, input int n, output int k);
		k = 0;
		repeat (n) begin
			tick(1);
			if (s === 1'b1) k++;
		end
	endtask : count

	task automatic boot(input logic fl, input logic [3:0] bd, input logic mn, input logic vb,
		input logic [1:0] ans);
		rst_n_in = 1'b0;
		flash_data_in_pin_in = fl;
		first_analog_input_pin_in = bd;
		main_supply_input_in = mn;
		vbus_present_in = vb;
		answer = ans;
		tick(5);
		rst_n_in = 1'b1;
		tick(4);
	endtask : boot

	task automatic check_profile(input logic [2:0] k);
		if (k == 3'h0 || k == 3'h7) begin
			chk1(ports_enabled_out, 1'b0, "ports off");
			chk1(legacy_sink_out, vbus_present_in, "legacy sink");
		end else begin
			chk1(ports_enabled_out, 1'b1, "ports on");
			chk1(alt_modes_out, 1'b0, "alt modes");
			chk1(ext_switch_out, k > 3'h4, "external switch");
			if (k != 3'h3 && k != 3'h4) chk(src_mv_out, V5_MV, "source mV");
			if (k != 3'h3 && k != 3'h4) chk(src_ma_out, I30_MA, "source mA");
			if (k != 3'h2) chk(snk_min_mv_out, V5_MV, "sink min mV");
			if (k != 3'h2) chk(snk_max_mv_out, k[0] ? V5_MV : V20_MV, "sink max mV");
			if (k != 3'h2) chk(snk_min_ma_out, I09_MA, "sink min mA");
			if (k != 3'h2) chk(snk_max_ma_out, I30_MA, "sink max mA");
			if (k < 3'h5) chk(16'(port_role_out), (k == 3'h2) ? 16'(BDPS_ROLE_SOURCE)
				: 16'(BDPS_ROLE_SINK), "port role");
		end
	endtask : check_profile

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		{rst_n_in, flash_data_in_pin_in, main_supply_input_in, vbus_present_in} = 4'h0;
		{port_connected_in, attach_change_in, i2c_activity_in, idle_req_in} = 4'h0;
		{sleep_req_in, slow, pd_send, answer, first_analog_input_pin_in} = 9'h000;
		for (int p = 1; p < 3; p++) begin
			foreach (ROWS[i]) begin
				r = ROWS[i];
				slow = (p == 2);
				boot(r[12], r[11:8], 1'b1, 1'b0, 2'(p));
				chk(16'(db_mode_out), 16'(r[6:4]), "dead battery mode");
				chk(16'(default_cfg_out), 16'(r[2:0]), "default config");
				wait_bit(cfg_fetch_out, 1'b1, 20, "fetch started");
				inf = r[2:0] == 3'h1 || r[6:4] == 3'h2 || r[6:4] == 3'h4;
				if (p == 2 && inf) begin
					tick(60);
					chk1(boot_busy_out, 1'b1, "still in boot");
					answer = 2'h1;
				end
				wait_bit(boot_busy_out, 1'b0, 80, "boot done");
				chk1(default_applied_out, p == 2 && !inf, "default used");
				if (p == 2 && !inf) check_profile(r[2:0]);
			end
			$display("test boot pass %0d done", p);
		end
		boot(1'b1, 4'h6, 1'b0, 1'b1, 2'h2);
		wait_bit(boot_busy_out, 1'b0, 80, "vbus boot");
		check_profile(3'h0);
		chk1(sink_only_out, 1'b1, "sink only");
		for (int k = 0; k < 2; k++) begin
			boot(1'b1, k[0] ? 4'h2 : 4'h4, 1'b0, 1'b1, 2'h1);
			tick(20);
			chk1(cfg_fetch_out, 1'b0, "waits for supply");
			chk1(external_sink_switch_ctl_out, !k[0], "external sink switch");
			chk1(first_internal_hv_path_out, k[0], "internal sink path");
			main_supply_input_in = 1'b1;
			wait_bit(cfg_fetch_out, 1'b1, 20, "fetch after supply");
		end
		$display("test dead battery done");
		boot(1'b1, 4'h0, 1'b1, 1'b0, 2'h1);
		wait_bit(boot_busy_out, 1'b0, 40, "power boot");
		port_connected_in = 1'b1;
		wait_bit(pd_en_out, 1'b1, 300, "pd on in active");
		chk1(spi_en_out, 1'b1, "spi on in active");
		count(core_tick_out, 20, c);
		chk(16'(c), 16'h000C, "active core ticks");
		count(timer_tick_out, 400, c);
		chk(16'(c), 16'h0002, "timer ticks");
		idle_req_in = 1'b1;
		wait_pwr(BDPS_PWR_IDLE, 10);
		idle_req_in = 1'b0;
		tick(3);
		chk1(pd_en_out | spi_en_out, 1'b0, "pd and spi off in idle");
		chk1(i2c_en_out & fast_osc_en_out, 1'b1, "i2c and osc on in idle");
		count(core_tick_out, 40, c);
		chk(16'(c), 16'h000A, "idle core ticks");
		sleep_req_in = 1'b1;
		tick(20);
		chk(16'(pwr_state_out), 16'(BDPS_PWR_IDLE), "no sleep when connected");
		pd_send = 1'b1;
		tick(1);
		pd_send = 1'b0;
		wait_pwr(BDPS_PWR_ACTIVE, 10);
		tick(30);
		chk(16'(drops), 16'h0001, "only first message lost");
		port_connected_in = 1'b0;
		wait_pwr(BDPS_PWR_SLEEP, 10);
		sleep_req_in = 1'b0;
		tick(2);
		chk1(fast_osc_en_out | i2c_en_out | pd_en_out, 1'b0, "sleep stops osc and buses");
		count(core_tick_out, 400, c);
		chk(16'(c), 16'h0002, "sleep core ticks");
		pd_send = 1'b1;
		tick(1);
		pd_send = 1'b0;
		tick(30);
		chk(16'(pwr_state_out), 16'(BDPS_PWR_SLEEP), "pd does not wake sleep");
		for (int k = 0; k < 2; k++) begin
			sleep_req_in = 1'b1;
			wait_pwr(BDPS_PWR_SLEEP, 10);
			sleep_req_in = 1'b0;
			tick(2);
			if (k == 0) attach_change_in = 1'b1;
			else i2c_activity_in = 1'b1;
			wait_pwr(BDPS_PWR_ACTIVE, 20);
			{attach_change_in, i2c_activity_in} = 2'h0;
			chk1(pd_en_out, 1'b0, "pd waits for fast osc");
			wait_bit(i2c_en_out, 1'b1, 300, "i2c after osc start");
			chk1(fast_osc_en_out, 1'b1, "fast osc restarted");
		end
		$display("test power states done");
		stop_test();
	end
endmodule : bdps_ctl_tb

bind bdps_ctl bdps_ctl_sva u_sva (.*);
